// ==== src/mbs_addr_gen.sv ====
// Burst address generator: fixed or incrementing address
`timescale 1ns/100ps
`default_nettype none
module mbs_addr_gen
    import mbs_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      reset_n,
    input  wire logic      dyn_sizing,
    input  wire logic      load,
    input  wire mbs_addr_t load_addr,
    input  wire logic      step,
    output mbs_addr_t      cur_addr
);
    mbs_addr_t addr_r;
    mbs_addr_t addr_nxt;

    // Next address: load once, then hold or increment
    always_comb begin
        addr_nxt = addr_r;
        if (load) begin
            addr_nxt = load_addr;
        end else if (step && dyn_sizing) begin
            addr_nxt = addr_r + mbs_addr_t'(1);
        end
    end

    // Register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            addr_r <= `MBS_ADDR_RST;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    assign cur_addr = addr_r;

    addr_fixed_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!load && !dyn_sizing) |=> $stable(addr_r))
        else $error("address moved under native alignment");
    addr_incr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!load && dyn_sizing && step) |=> addr_r == $past(addr_r) + mbs_addr_t'(1))
        else $error("address did not step by one");
endmodule
`default_nettype wire

// ==== src/mbs_burst_slave.sv ====
// Burst logic of a memory-mapped slave port
// Behaviour
// - Burst of length B from address A performs exactly B transfers.
// - Address latched once at acceptance; later addresses generated internally.
// - Native alignment keeps every unit at the latched address.
// - Dynamic bus sizing increments address by one per unit.
// - Write start: first edge with waitrequest low latches address, length, data.
// - Write burst of N needs N accepted write data units.
// - Write data sampled only when write high; low write pauses burst.
// - Slave may stall with waitrequest; fabric holds data and enables.
// - Read start: first edge with waitrequest low latches address and length.
// - Read burst of N returns N read data units.
// - Each read unit is one cycle of readdatavalid with readdata.
// - Readdatavalid may stay low any number of cycles between units.
// - No read data before the edge after address acceptance.
// - Port implements both waitrequest and readdatavalid.
`timescale 1ns/100ps
`default_nettype none
module mbs_burst_slave
    import mbs_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           reset_n,
    input  wire logic           dyn_sizing,
    input  wire logic           mem_busy,
    input  wire logic           chipselect,
    input  wire mbs_pkg::mbs_addr_t address,
    input  wire mbs_pkg::mbs_be_t   byteenable,
    input  wire logic           write,
    input  wire mbs_pkg::mbs_data_t writedata,
    input  wire logic           read,
    input  wire mbs_pkg::mbs_cnt_t  burstcount,
    input  wire logic           beginbursttransfer,
    input  wire logic           rd_stall,
    input  wire mbs_pkg::mbs_data_t mem_rdata,
    output logic                waitrequest,
    output logic                readdatavalid,
    output mbs_pkg::mbs_data_t  readdata,
    output logic                mem_we,
    output logic                mem_re,
    output mbs_pkg::mbs_addr_t  mem_addr,
    output mbs_pkg::mbs_data_t  mem_wdata,
    output mbs_pkg::mbs_be_t    mem_be,
    output logic                burst_done
);
    import mbs_pkg::*;

    // Cleaned-up length: a zero count is taken as one unit
    function automatic mbs_cnt_t norm_len(input mbs_cnt_t c);
        norm_len = (c == `MBS_CNT_RST) ? mbs_cnt_t'(1) : c;
    endfunction

    mbs_state_t state_r;
    mbs_state_t state_nxt;
    logic       wait_r;
    logic       wait_nxt;
    logic       rdv_r;
    logic       rdv_nxt;
    mbs_data_t  rdata_r;
    mbs_data_t  rdata_nxt;
    logic       we_r;
    logic       we_nxt;
    logic       re_r;
    logic       re_nxt;
    mbs_addr_t  maddr_r;
    mbs_addr_t  maddr_nxt;
    mbs_data_t  wdata_r;
    mbs_data_t  wdata_nxt;
    mbs_be_t    be_r;
    mbs_be_t    be_nxt;
    logic       done_r;
    logic       done_nxt;
    logic [`MBS_RD_LAT-1:0] rd_pipe_r;
    logic [`MBS_RD_LAT-1:0] rd_pipe_nxt;
    mbs_cnt_t   issued_r;
    mbs_cnt_t   issued_nxt;

    // Start and unit strobes
    logic      accept_wr;
    logic      accept_rd;
    logic      wr_unit;
    logic      rd_issue;
    logic      rd_ret;
    logic      cnt_load;
    mbs_cnt_t  remain;
    logic      last_unit;
    mbs_addr_t cur_addr;
    mbs_addr_t unit_addr;

    // Acceptance: request seen while waitrequest low
    assign accept_wr = (state_r == MBS_IDLE) && chipselect && write && !wait_r;
    assign accept_rd = (state_r == MBS_IDLE) && chipselect && read && !write && !wait_r;
    assign wr_unit   = accept_wr || ((state_r == MBS_WRITE) && write && !wait_r);
    assign rd_issue  = (state_r == MBS_READ) && !rd_stall && (issued_r != `MBS_CNT_RST);
    assign rd_ret    = rd_pipe_r[`MBS_RD_LAT-1];
    assign cnt_load  = accept_wr || accept_rd;

    // First write unit goes to the fresh address, later ones to the generated one
    assign unit_addr = accept_wr ? address : cur_addr;

    mbs_addr_gen u_addr (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .dyn_sizing (dyn_sizing),
        .load       (accept_rd ? 1'b1 : accept_wr),
        .load_addr  (accept_wr ? address + mbs_addr_t'(dyn_sizing) : address),
        .step       (accept_wr ? 1'b0 : (wr_unit || rd_issue)),
        .cur_addr   (cur_addr)
    );

    mbs_unit_cnt u_cnt (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .load      (cnt_load),
        .load_cnt  (accept_wr ? norm_len(burstcount) - mbs_cnt_t'(1) : norm_len(burstcount)),
        .dec       ((state_r == MBS_WRITE && wr_unit) || (state_r == MBS_READ && rd_ret)),
        .remain    (remain),
        .last_unit (last_unit)
    );

    // Burst sequencing and port outputs
    always_comb begin
        state_nxt   = state_r;
        wait_nxt    = mem_busy;
        we_nxt      = 1'b0;
        re_nxt      = 1'b0;
        maddr_nxt   = maddr_r;
        wdata_nxt   = wdata_r;
        be_nxt      = be_r;
        done_nxt    = 1'b0;
        issued_nxt  = issued_r;
        rd_pipe_nxt = {rd_pipe_r[`MBS_RD_LAT-2:0], rd_issue};
        rdv_nxt     = rd_ret;
        rdata_nxt   = rd_ret ? mem_rdata : rdata_r;
        case (state_r)
            MBS_IDLE: begin
                if (accept_wr) begin
                    state_nxt = (norm_len(burstcount) == mbs_cnt_t'(1)) ? MBS_IDLE : MBS_WRITE;
                    done_nxt  = (norm_len(burstcount) == mbs_cnt_t'(1));
                end else if (accept_rd) begin
                    state_nxt  = MBS_READ;
                    issued_nxt = norm_len(burstcount);
                    wait_nxt   = 1'b1;
                end
            end
            MBS_WRITE: begin
                if (wr_unit && last_unit) begin
                    state_nxt = MBS_IDLE;
                    done_nxt  = 1'b1;
                end
            end
            MBS_READ: begin
                wait_nxt = 1'b1;
                if (rd_issue) begin
                    issued_nxt = issued_r - mbs_cnt_t'(1);
                end
                if (rd_ret && last_unit) begin
                    state_nxt = MBS_IDLE;
                    done_nxt  = 1'b1;
                    wait_nxt  = mem_busy;
                end
            end
            default: begin
                state_nxt = MBS_IDLE;
            end
        endcase
        // Write unit goes to memory; read issue reads the generated address
        if (wr_unit) begin
            we_nxt    = 1'b1;
            maddr_nxt = unit_addr;
            wdata_nxt = writedata;
            be_nxt    = byteenable;
        end else if (rd_issue) begin
            re_nxt    = 1'b1;
            maddr_nxt = cur_addr;
        end
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r   <= MBS_IDLE;
            wait_r    <= 1'b1;
            rdv_r     <= 1'b0;
            rdata_r   <= `MBS_DATA_RST;
            we_r      <= 1'b0;
            re_r      <= 1'b0;
            maddr_r   <= `MBS_ADDR_RST;
            wdata_r   <= `MBS_DATA_RST;
            be_r      <= '0;
            done_r    <= 1'b0;
            rd_pipe_r <= '0;
            issued_r  <= `MBS_CNT_RST;
        end else begin
            state_r   <= state_nxt;
            wait_r    <= wait_nxt;
            rdv_r     <= rdv_nxt;
            rdata_r   <= rdata_nxt;
            we_r      <= we_nxt;
            re_r      <= re_nxt;
            maddr_r   <= maddr_nxt;
            wdata_r   <= wdata_nxt;
            be_r      <= be_nxt;
            done_r    <= done_nxt;
            rd_pipe_r <= rd_pipe_nxt;
            issued_r  <= issued_nxt;
        end
    end

    assign waitrequest   = wait_r;
    assign readdatavalid = rdv_r;
    assign readdata      = rdata_r;
    assign mem_we        = we_r;
    assign mem_re        = re_r;
    assign mem_addr      = maddr_r;
    assign mem_wdata     = wdata_r;
    assign mem_be        = be_r;
    assign burst_done    = done_r;

    // Checks
    wr_sample_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_r == MBS_WRITE && !write) |=> !mem_we)
        else $error("write data taken while write low");
    wr_accept_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        accept_wr |=> mem_we && mem_addr == $past(address) && mem_wdata == $past(writedata))
        else $error("first write unit not captured");
    rd_early_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        accept_rd |=> !readdatavalid)
        else $error("read data returned too early");
    rd_lat_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        mem_re |-> ##2 readdatavalid)
        else $error("read unit not returned after two cycles");
    rd_wait_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_r == MBS_READ) |-> waitrequest)
        else $error("new request allowed during read burst");
    done_wr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_r == MBS_WRITE && wr_unit && remain == mbs_cnt_t'(1)) |=> burst_done && state_r == MBS_IDLE)
        else $error("write burst did not finish on last unit");
    done_rd_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_r == MBS_READ && rd_ret && remain == mbs_cnt_t'(1)) |=> burst_done ##1 !readdatavalid)
        else $error("read burst did not finish on last unit");
    rdv_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (readdatavalid && state_r == MBS_IDLE) |=> !readdatavalid)
        else $error("stray read data after burst");

    wr_burst_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        accept_wr && burstcount == mbs_cnt_t'(4) ##[1:40] burst_done);
    rd_burst_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        accept_rd && burstcount == mbs_cnt_t'(4) ##[1:40] burst_done);
    wr_pause_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        state_r == MBS_WRITE && !write ##1 write);
    rd_gap_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        readdatavalid ##1 !readdatavalid ##1 readdatavalid);
endmodule
`default_nettype wire

// ==== src/mbs_defines.svh ====
// Widths, read latency and reset values of the burst slave port
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH

`define MBS_ADDR_W      16
`define MBS_DATA_W      32
`define MBS_BE_W        4
`define MBS_CNT_W       8
`define MBS_ADDR_RST    16'h0000
`define MBS_CNT_RST     8'h00
`define MBS_DATA_RST    32'h0000_0000
`define MBS_RD_LAT      2

`endif

// ==== src/mbs_pkg.sv ====
// Types shared by the burst slave port modules
`include "mbs_defines.svh"
package mbs_pkg;
    typedef logic [`MBS_ADDR_W-1:0] mbs_addr_t;
    typedef logic [`MBS_DATA_W-1:0] mbs_data_t;
    typedef logic [`MBS_BE_W-1:0]   mbs_be_t;
    typedef logic [`MBS_CNT_W-1:0]  mbs_cnt_t;
    typedef enum logic [1:0] {
        MBS_IDLE,
        MBS_WRITE,
        MBS_READ
    } mbs_state_t;
endpackage

// ==== src/mbs_unit_cnt.sv ====
// Remaining-units counter of a burst
`timescale 1ns/100ps
`default_nettype none
module mbs_unit_cnt
    import mbs_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     reset_n,
    input  wire logic     load,
    input  wire mbs_cnt_t load_cnt,
    input  wire logic     dec,
    output mbs_cnt_t      remain,
    output logic          last_unit
);
    mbs_cnt_t cnt_r;
    mbs_cnt_t cnt_nxt;

    // Load on acceptance, count down per unit
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = load_cnt;
        end else if (dec && cnt_r != `MBS_CNT_RST) begin
            cnt_nxt = cnt_r - mbs_cnt_t'(1);
        end
    end

    // Register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_r <= `MBS_CNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign remain    = cnt_r;
    assign last_unit = (cnt_r == mbs_cnt_t'(1));

    cnt_dec_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!load && dec && cnt_r != 0) |=> cnt_r == $past(cnt_r) - mbs_cnt_t'(1))
        else $error("unit counter did not decrement");
endmodule
`default_nettype wire

// ==== test/mbs_burst_slave_tb.sv ====
// Self-checking bench of the burst slave port
`timescale 1ns/100ps
`default_nettype none
module mbs_burst_slave_tb;
    import mbs_pkg::*;
    typedef struct {logic dyn; logic rd; mbs_addr_t a; mbs_cnt_t n;} mbs_row_t;
    logic      ref_clk, reset_n, dyn_sizing, mem_busy, rd_stall, stall_en, fab_to;
    logic      chipselect, write, read, beginbursttransfer;
    logic      waitrequest, readdatavalid, mem_we, mem_re, burst_done, exp_dyn;
    mbs_addr_t address, mem_addr, exp_a, exp_b;
    mbs_addr_t pipe_a [2];
    mbs_be_t   byteenable, mem_be;
    mbs_cnt_t  burstcount;
    mbs_data_t writedata, readdata, mem_rdata, mem_wdata, exp_d;
    int        bad_count, n_checks, units, exp_n, dones, re_units;
    mbs_row_t  rows [7] = '{'{0, 0, 16'h1000, 8'h0A}, '{1, 0, 16'h1000, 8'h04}, '{0, 1, 16'h2000, 8'h03},
                            '{1, 1, 16'h2000, 8'h04}, '{1, 0, 16'hFFFE, 8'h04}, '{1, 1, 16'h0FFF, 8'h01},
                            '{0, 0, 16'h0010, 8'h00}};

    mbs_burst_slave DUT (.ref_clk(ref_clk), .reset_n(reset_n), .dyn_sizing(dyn_sizing), .mem_busy(mem_busy),
        .chipselect(chipselect), .address(address), .byteenable(byteenable), .write(write),
        .writedata(writedata), .read(read), .burstcount(burstcount), .beginbursttransfer(beginbursttransfer),
        .rd_stall(rd_stall), .mem_rdata(mem_rdata), .waitrequest(waitrequest), .readdatavalid(readdatavalid),
        .readdata(readdata), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_be(mem_be), .burst_done(burst_done));
    mbs_fabric_model fab (.ref_clk(ref_clk), .waitrequest(waitrequest), .chipselect(chipselect),
        .address(address), .byteenable(byteenable), .write(write), .writedata(writedata), .read(read),
        .burstcount(burstcount), .beginbursttransfer(beginbursttransfer), .timed_out(fab_to));

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Memory answers one edge after the read strobe with data of its address
    always @(posedge ref_clk) begin
        pipe_a[0] <= mem_addr;
        pipe_a[1] <= pipe_a[0];
        rd_stall <= stall_en & ~rd_stall;
    end
    assign mem_rdata = {~pipe_a[0], pipe_a[0]};

    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_data(input string nm, input mbs_data_t e, input mbs_data_t g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        chk_data(nm, mbs_data_t'(e), mbs_data_t'(g));
    endtask

    // Monitor of written and returned units
    always @(posedge ref_clk) begin
        if (mem_we === 1'b1) begin
            chk_data("mem_addr", {16'h0000, exp_a + (exp_dyn ? mbs_addr_t'(units) : 16'h0000)}, {16'h0000, mem_addr});
            chk_data("mem_wdata", exp_d + mbs_data_t'(units), mem_wdata);
            chk_data("mem_be", 32'h0000_000F, {28'h000_0000, mem_be});
            units++;
        end
        if (mem_re === 1'b1) begin
            chk_data("mem_re_addr", {16'h0000, exp_b + (exp_dyn ? mbs_addr_t'(re_units) : 16'h0000)}, {16'h0000, mem_addr});
            re_units++;
        end
        if (readdatavalid === 1'b1) begin
            exp_a = exp_a + (exp_dyn ? 16'h0001 : 16'h0000);
            chk_data("readdata", {~(exp_a - (exp_dyn ? 16'h0001 : 16'h0000)), exp_a - (exp_dyn ? 16'h0001 : 16'h0000)}, readdata);
            units++;
        end
        if (burst_done === 1'b1) begin
            chk_cnt("units", exp_n, units);
            dones++;
        end
    end

    always @(posedge fab_to) begin
        bad_count++;
        report_and_stop();
    end

    // One burst from a row, then a bounded wait for its completion
    task automatic run(input mbs_row_t r, input int gap);
        int target;
        int n;
        target = dones + 1;
        n = 0;
        exp_a = r.a;
        exp_b = r.a;
        re_units = 0;
        exp_dyn = r.dyn;
        exp_d = {16'hA000, r.a};
        exp_n = (r.n == 8'h00) ? 1 : int'(r.n);
        units = 0;
        dyn_sizing <= r.dyn;
        if (r.rd) begin
            fab.rd_burst(r.a, r.n);
        end else begin
            fab.wr_burst(r.a, r.n, exp_d, gap);
        end
        while (dones < target) begin
            @(posedge ref_clk);
            n++;
            if (n > 300) begin
                bad_count++;
                report_and_stop();
            end
        end
    endtask

    initial begin
        reset_n = 1'b0;
        dyn_sizing = 1'b0;
        mem_busy = 1'b0;
        stall_en = 1'b0;
        rd_stall = 1'b0;
        pipe_a = '{16'h0000, 16'h0000};
        {bad_count, n_checks, units, dones, exp_n, re_units} = '0;
        exp_b = 16'h0000;
        repeat (5) @(posedge ref_clk);
        chk_data("waitrequest", 32'h0000_0001, {31'h0000_0000, waitrequest});
        chk_data("readdatavalid", 32'h0000_0000, {31'h0000_0000, readdatavalid});
        reset_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            run(rows[i], 0);
        end
        // Stalled opening and paused write
        mem_busy <= 1'b1;
        @(posedge ref_clk);
        fork
            begin
                repeat (4) @(posedge ref_clk);
                mem_busy <= 1'b0;
            end
        join_none
        run('{1, 0, 16'h3000, 8'h05}, 2);
        // Read with gaps between returned units
        stall_en <= 1'b1;
        run('{1, 1, 16'h4000, 8'h06}, 0);
        stall_en <= 1'b0;
        // Reset with read data outstanding, then a fresh burst
        fab.rd_burst(16'h5000, 8'h08);
        reset_n <= 1'b0;
        @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        chk_data("waitrequest", 32'h0000_0001, {31'h0000_0000, waitrequest});
        repeat (12) @(posedge ref_clk);
        run('{0, 1, 16'h6000, 8'h02}, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== test/mbs_fabric_model.sv ====
// Fabric-side model that opens write and read bursts on the slave port
`timescale 1ns/100ps
`default_nettype none
module mbs_fabric_model (
    input  wire logic           ref_clk,
    input  wire logic           waitrequest,
    output logic                chipselect,
    output mbs_pkg::mbs_addr_t  address,
    output mbs_pkg::mbs_be_t    byteenable,
    output logic                write,
    output mbs_pkg::mbs_data_t  writedata,
    output logic                read,
    output mbs_pkg::mbs_cnt_t   burstcount,
    output logic                beginbursttransfer,
    output logic                timed_out
);
    import mbs_pkg::*;

    // Control lines and byteenable drop low; address, burstcount and writedata show the inverse of their last value
    task automatic release_bus();
        chipselect <= 1'b0;
        write <= 1'b0;
        read <= 1'b0;
        beginbursttransfer <= 1'b0;
        byteenable <= 4'h0;
        address <= ~address;
        burstcount <= ~burstcount;
        writedata <= ~writedata;
    endtask

    // Hold the request until an edge sees waitrequest low
    task automatic wait_accept();
        logic taken;
        int   n;
        taken = 1'b0;
        n = 0;
        while (!taken) begin
            @(negedge ref_clk);
            taken = (waitrequest === 1'b0);
            n++;
            if (n > 300) begin
                timed_out = 1'b1;
            end
            @(posedge ref_clk);
        end
    endtask

    // Opening cycle of a burst, held through any stall
    task automatic open_burst(input mbs_addr_t a, input mbs_cnt_t n);
        chipselect <= 1'b1;
        address <= a;
        burstcount <= n;
        byteenable <= 4'hF;
        beginbursttransfer <= 1'b1;
        wait_accept();
        beginbursttransfer <= 1'b0;
        address <= ~a;
        burstcount <= ~n;
    endtask

    // Write burst, optionally pausing write before each later unit
    task automatic wr_burst(input mbs_addr_t a, input mbs_cnt_t n, input mbs_data_t d0, input int gap);
        int units;
        units = (n == 8'h00) ? 1 : int'(n);
        write <= 1'b1;
        writedata <= d0;
        open_burst(a, n);
        for (int k = 1; k < units; k++) begin
            if (gap > 0) begin
                chipselect <= 1'b0;
                write <= 1'b0;
                writedata <= ~writedata;
                repeat (gap) @(posedge ref_clk);
                chipselect <= 1'b1;
                write <= 1'b1;
            end
            writedata <= d0 + mbs_data_t'(k);
            wait_accept();
        end
        release_bus();
    endtask

    // Read burst: single address phase, data returns afterwards
    task automatic rd_burst(input mbs_addr_t a, input mbs_cnt_t n);
        read <= 1'b1;
        open_burst(a, n);
        release_bus();
    endtask

    initial begin
        timed_out = 1'b0;
        chipselect = 1'b0;
        write = 1'b0;
        read = 1'b0;
        beginbursttransfer = 1'b0;
        byteenable = 4'h0;
        address = 16'h0000;
        burstcount = 8'h00;
        writedata = 32'h0000_0000;
    end
endmodule
`default_nettype wire
